// [core/xoc_pkg.sv]
package xoc_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [11:0] XOC_STATUS_OFS  = 12'h00c;
	localparam logic [11:0] XOC_CTRL_OFS    = 12'h010;
	localparam int          XOC_ADDR_W      = 12;

	// ==========================================================
	// Control register layout
	localparam logic [15:0] XOC_CTRL_RESET  = 16'h0080;
	localparam logic [15:0] XOC_CTRL_WMASK  = 16'hffde;
	localparam int          XOC_STARTUP_LSB = 12;
	localparam int          XOC_AUTO_AMP    = 11;
	localparam int          XOC_GAIN_LSB    = 8;
	localparam int          XOC_ON_REQUEST  = 7;
	localparam int          XOC_RUN_STANDBY = 6;
	localparam int          XOC_SWITCH_BACK = 4;
	localparam int          XOC_DETECT_EN   = 3;
	localparam int          XOC_XTAL_SEL    = 2;
	localparam int          XOC_ENABLE      = 1;
	localparam logic [2:0]  XOC_GAIN_MAX    = 3'h4;

	// ==========================================================
	// Status register layout
	localparam int XOC_ST_RATIO_DONE = 11;
	localparam int XOC_ST_LOCK_TO    = 10;
	localparam int XOC_ST_LOCK_FALL  = 9;
	localparam int XOC_ST_LOCK_RISE  = 8;
	localparam int XOC_ST_RC48_RDY   = 4;
	localparam int XOC_ST_SWITCHED   = 2;
	localparam int XOC_ST_FAIL       = 1;
	localparam int XOC_ST_READY      = 0;

	// ==========================================================
	// Timing
	localparam int XOC_CLK_PERIOD_NS  = 10;
	localparam int XOC_CFD_TIMEOUT_NS = 1000;
	localparam int XOC_CFD_TIMEOUT_CYC = (XOC_CFD_TIMEOUT_NS / XOC_CLK_PERIOD_NS < 1) ? 1 :
		XOC_CFD_TIMEOUT_NS / XOC_CLK_PERIOD_NS;
	localparam logic [1:0] XOC_OSC_WAIT_EDGES = 2'h3;

	// ==========================================================
	// Bus answers
	localparam logic [1:0] XOC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] XOC_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		XOC_SU_IDLE  = 2'b00,
		XOC_SU_OSC   = 2'b01,
		XOC_SU_COUNT = 2'b10,
		XOC_SU_READY = 2'b11
	} xoc_su_state_e;

endpackage

// [core/xoc_start_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface xoc_start_if;
	logic       run;
	logic       osc_edge;
	logic       ulp_tick;
	logic [3:0] startup_sel;
	logic       ready;

	modport ctrl (output run, output osc_edge, output ulp_tick, output startup_sel, input ready);
	modport cnt  (input run, input osc_edge, input ulp_tick, input startup_sel, output ready);
endinterface
`default_nettype wire

// [core/xoc_startup.sv]
`timescale 1ns/1ns
`default_nettype none
module xoc_startup
	import xoc_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Link to controller
	xoc_start_if.cnt su
);

	xoc_su_state_e state;
	logic [1:0]    osc_cnt;
	logic [15:0]   ulp_cnt;

	// ==========================================================
	// Start-up sequence: oscillator edges, then low-power ticks
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state   <= XOC_SU_IDLE;
			osc_cnt <= 2'h0;
			ulp_cnt <= 16'h0000;
		end else if (!su.run) begin
			state   <= XOC_SU_IDLE;
			osc_cnt <= 2'h0;
			ulp_cnt <= 16'h0000;
		end else begin
			case (state)
				XOC_SU_IDLE: begin
					state <= XOC_SU_OSC;
				end
				XOC_SU_OSC: begin
					if (su.osc_edge) begin
						osc_cnt <= osc_cnt + 2'h1;
						if (osc_cnt == XOC_OSC_WAIT_EDGES - 2'h1) begin
							state <= XOC_SU_COUNT;
						end
					end
				end
				XOC_SU_COUNT: begin
					if (su.ulp_tick) begin
						ulp_cnt <= ulp_cnt + 16'h0001;
						if (ulp_cnt == 16'((17'h1 << su.startup_sel) - 17'h1)) begin
							state <= XOC_SU_READY;
						end
					end
				end
				XOC_SU_READY: begin
					state <= XOC_SU_READY;
				end
				default: begin
					state <= XOC_SU_IDLE;
				end
			endcase
		end
	end

	assign su.ready = (state == XOC_SU_READY);

	a_ready_after_osc: assert property (@(posedge aclk) disable iff (!aresetn)
		(state == XOC_SU_OSC) ##1 (state == XOC_SU_COUNT) |-> $past(osc_cnt) == 2'h2)
		else $error("start-up count began before three oscillator edges");
	a_ready_needs_run: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(su.ready) |-> $past(su.run) && $past(su.ulp_tick))
		else $error("ready rose without a low-power tick");

endmodule
`default_nettype wire

// [core/xoc_ctrl.sv]
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module xoc_ctrl
	import xoc_pkg::*;
#(
	parameter int CFD_CNT_W = 16
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address and data
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Oscillator side
	input  wire logic        osc_clk_level,
	input  wire logic        ulp_32k_level,
	input  wire logic        periph_clk_request,
	input  wire logic        standby_sleep,
	output logic             osc_run,
	output logic             crystal_mode_select,
	output logic [2:0]       osc_gain,
	output logic             auto_amplitude_control,
	output logic             safe_clock_select,
	output logic             crystal_ready,
	// Neighbour status
	input  wire logic        internal_48mhz_ready,
	input  wire logic        pll_lock,
	input  wire logic        pll_lock_timeout,
	input  wire logic        pll_ratio_update_done
);

	xoc_start_if su ();

	logic [15:0]          ctrl;
	logic [31:0]          status;
	logic                 osc_prev;
	logic                 ulp_prev;
	logic                 osc_edge;
	logic                 next_run;
	logic                 fail;
	logic                 switched;
	logic [CFD_CNT_W-1:0] cfd_cnt;
	logic                 lock_prev;
	logic                 lock_rise_seen;
	logic                 lock_fall_seen;
	logic                 rc48_rdy;
	logic                 pll_to;
	logic                 pll_ratio;
	logic                 aw_got;
	logic                 w_got;
	logic [11:0]          aw_addr;
	logic [31:0]          w_data;
	logic [3:0]           w_strb;
	logic                 do_write;
	logic                 swb_done;

	function automatic logic [11:0] word_addr(input logic [11:0] a);
		return {a[11:2], 2'b00};
	endfunction

	// ==========================================================
	// Edge detection on sampled oscillator levels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_prev <= 1'b0;
			ulp_prev <= 1'b0;
		end else begin
			osc_prev <= osc_clk_level;
			ulp_prev <= ulp_32k_level;
		end
	end

	assign osc_edge = osc_clk_level & ~osc_prev;

	// ==========================================================
	// Run policy
	always_comb begin
		if (!ctrl[XOC_ENABLE]) begin
			next_run = 1'b0;
		end else if (ctrl[XOC_ON_REQUEST]) begin
			next_run = periph_clk_request;
		end else if (standby_sleep) begin
			next_run = ctrl[XOC_RUN_STANDBY] | periph_clk_request;
		end else begin
			next_run = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_run <= 1'b0;
		end else begin
			osc_run <= next_run;
		end
	end

	// ==========================================================
	// Start-up counter
	assign su.run         = osc_run;
	assign su.osc_edge    = osc_edge;
	assign su.ulp_tick    = ulp_32k_level & ~ulp_prev;
	assign su.startup_sel = ctrl[XOC_STARTUP_LSB +: 4];

	xoc_startup u_startup (
		.aclk    (aclk),
		.aresetn (aresetn),
		.su      (su)
	);

	// ==========================================================
	// Pad and analog controls
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			crystal_mode_select    <= 1'b0;
			osc_gain               <= 3'h0;
			auto_amplitude_control <= 1'b0;
			crystal_ready          <= 1'b0;
		end else begin
			crystal_mode_select    <= ctrl[XOC_XTAL_SEL];
			osc_gain               <= ctrl[XOC_GAIN_LSB +: 3];
			auto_amplitude_control <= ctrl[XOC_AUTO_AMP] & su.ready;
			crystal_ready          <= su.ready;
		end
	end

	// ==========================================================
	// Clock failure detector
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfd_cnt  <= '0;
			fail     <= 1'b0;
			switched <= 1'b0;
			swb_done <= 1'b0;
		end else begin
			swb_done <= 1'b0;
			if (!ctrl[XOC_DETECT_EN] || !osc_run) begin
				cfd_cnt <= '0;
				fail    <= 1'b0;
			end else if (osc_edge) begin
				cfd_cnt <= '0;
				fail    <= 1'b0;
				if (switched && ctrl[XOC_SWITCH_BACK]) begin
					switched <= 1'b0;
					swb_done <= 1'b1;
				end
			end else if (cfd_cnt >= CFD_CNT_W'(XOC_CFD_TIMEOUT_CYC - 1)) begin
				fail     <= 1'b1;
				switched <= 1'b1;
			end else begin
				cfd_cnt <= cfd_cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			safe_clock_select <= 1'b0;
		end else begin
			safe_clock_select <= switched;
		end
	end

	// ==========================================================
	// Neighbour status capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock_prev      <= 1'b0;
			lock_rise_seen <= 1'b0;
			lock_fall_seen <= 1'b0;
			rc48_rdy       <= 1'b0;
			pll_to         <= 1'b0;
			pll_ratio      <= 1'b0;
		end else begin
			lock_prev <= pll_lock;
			if (pll_lock && !lock_prev) begin
				lock_rise_seen <= 1'b1;
				lock_fall_seen <= 1'b0;
			end else if (!pll_lock && lock_prev) begin
				lock_rise_seen <= 1'b0;
				lock_fall_seen <= 1'b1;
			end
			rc48_rdy  <= internal_48mhz_ready;
			pll_to    <= pll_lock_timeout;
			pll_ratio <= pll_ratio_update_done;
		end
	end

	always_comb begin
		status                    = 32'h0000_0000;
		status[XOC_ST_RATIO_DONE] = pll_ratio;
		status[XOC_ST_LOCK_TO]    = pll_to;
		status[XOC_ST_LOCK_FALL]  = lock_fall_seen;
		status[XOC_ST_LOCK_RISE]  = lock_rise_seen;
		status[XOC_ST_RC48_RDY]   = rc48_rdy;
		status[XOC_ST_SWITCHED]   = switched;
		status[XOC_ST_FAIL]       = fail;
		status[XOC_ST_READY]      = su.ready;
	end

	// ==========================================================
	// AXI4-Lite write channel
	assign do_write = aw_got && w_got && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got        <= 1'b0;
			w_got         <= 1'b0;
			aw_addr       <= 12'h000;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= XOC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got        <= 1'b1;
				aw_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end else if (!aw_got && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got        <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end else if (!w_got && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (word_addr(aw_addr) == XOC_CTRL_OFS ||
					word_addr(aw_addr) == XOC_STATUS_OFS) ? XOC_RESP_OKAY : XOC_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_got       <= 1'b0;
				w_got        <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Control register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= XOC_CTRL_RESET;
		end else begin
			if (do_write && word_addr(aw_addr) == XOC_CTRL_OFS) begin
				if (w_strb[0]) begin
					ctrl[7:0] <= w_data[7:0] & XOC_CTRL_WMASK[7:0];
				end
				if (w_strb[1]) begin
					ctrl[15:11] <= w_data[15:11];
					if (w_data[10:8] <= XOC_GAIN_MAX) begin
						ctrl[10:8] <= w_data[10:8];
					end
				end
			end
			if (swb_done) begin
				ctrl[XOC_SWITCH_BACK] <= 1'b0;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= XOC_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				if (word_addr(s_axi_araddr) == XOC_CTRL_OFS) begin
					s_axi_rdata <= {16'h0000, ctrl};
					s_axi_rresp <= XOC_RESP_OKAY;
				end else if (word_addr(s_axi_araddr) == XOC_STATUS_OFS) begin
					s_axi_rdata <= status;
					s_axi_rresp <= XOC_RESP_OKAY;
				end else begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= XOC_RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Checks
	a_ctrl_reset: assert property (@(posedge aclk)
		$rose(aresetn) |-> ctrl == XOC_CTRL_RESET)
		else $error("control register not at reset value");
	a_run_off_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
		!ctrl[XOC_ENABLE] |=> !osc_run)
		else $error("oscillator runs while disabled");
	a_run_on_request: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl[XOC_ENABLE] && ctrl[XOC_ON_REQUEST] |=> osc_run == $past(periph_clk_request))
		else $error("on-request run does not follow request");
	a_standby_stop: assert property (@(posedge aclk) disable iff (!aresetn)
		standby_sleep && !ctrl[XOC_RUN_STANDBY] && !periph_clk_request |=> !osc_run)
		else $error("oscillator runs in standby without request");
	a_gain_legal: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl[10:8] <= XOC_GAIN_MAX)
		else $error("reserved gain code stored");
	a_fail_switch: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(fail) |-> switched ##1 safe_clock_select)
		else $error("failure without safe clock switch");
	a_fail_needs_cfd: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(fail) |-> $past(ctrl[XOC_DETECT_EN]))
		else $error("failure flagged while detector disabled");
	a_swb_clears: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(switched) |-> ##1 !ctrl[XOC_SWITCH_BACK])
		else $error("switch-back bit not cleared after return");
	a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");

endmodule
`default_nettype wire

// [verif/xoc_xtal_model.sv]
`timescale 1ns/1ns
`default_nettype none
module xoc_xtal_model (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Run request and commanded stall
	input  wire logic osc_run,
	input  wire logic stall,
	// Clock levels
	output var logic  osc_clk_level,
	output var logic  ulp_32k_level
);
	logic [2:0] ulp_div;

	// ==========================================================
	// Low-power clock, free running, one tick every 16 cycles
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ulp_div       <= 3'h0;
			ulp_32k_level <= 1'b0;
		end else begin
			ulp_div <= ulp_div + 3'h1;
			if (ulp_div == 3'h7)
				ulp_32k_level <= ~ulp_32k_level;
		end
	end

	// ==========================================================
	// Oscillator stands still when stopped or stalled
	always_ff @(posedge aclk) begin
		if (!aresetn || !osc_run || stall)
			osc_clk_level <= 1'b0;
		else
			osc_clk_level <= ~osc_clk_level;
	end
endmodule
`default_nettype wire

// [verif/crystal_osc_control_status_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module crystal_osc_control_status_tb;
	import xoc_pkg::*;
	typedef struct {logic [11:0] a; logic [31:0] d; logic [3:0] s;
		logic [1:0] b; logic [31:0] q; logic [1:0] r;} xoc_row_s;
	typedef struct {logic [15:0] c; logic sb; logic rq; logic e;} xoc_pol_s;
	logic        aclk, aresetn, stall;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        osc_clk_level, ulp_32k_level, periph_clk_request, standby_sleep;
	logic        osc_run, crystal_mode_select, auto_amplitude_control, safe_clock_select, crystal_ready;
	logic [2:0]  osc_gain;
	logic        internal_48mhz_ready, pll_lock, pll_lock_timeout, pll_ratio_update_done, po, pu;
	int          failures, comparisons, cycles, oscr, ulpr;
	xoc_row_s    rows [13];
	xoc_pol_s    pol [9];

	xoc_ctrl u_xoc_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_clk_level,
		.ulp_32k_level, .periph_clk_request, .standby_sleep, .osc_run, .crystal_mode_select, .osc_gain,
		.auto_amplitude_control, .safe_clock_select, .crystal_ready, .internal_48mhz_ready, .pll_lock,
		.pll_lock_timeout, .pll_ratio_update_done);
	xoc_xtal_model u_xoc_xtal_model (.aclk, .aresetn, .osc_run, .stall, .osc_clk_level, .ulp_32k_level);

	// ==========================================================
	// Clock, timeout and start-up edge counting
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		po <= osc_clk_level;
		pu <= ulp_32k_level;
		if (!osc_run) begin
			oscr <= 0;
			ulpr <= 0;
		end else begin
			if (osc_clk_level && !po) oscr <= oscr + 1;
			if (ulp_32k_level && !pu && oscr >= 3 && !crystal_ready) ulpr <= ulpr + 1;
		end
		if (cycles == 5000) begin
			failures++;
			test_done();
		end
	end

	// ==========================================================
	// Bus and comparison tasks
	task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] q);
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata   <= v;
		s_axi_wstrb   <= s;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		q = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] q);
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		q = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
		logic [31:0] v;
		logic [1:0]  q;
		rd(a, v, q);
		chk(n, v & m, exp);
	endtask

	task automatic test_done;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		rows = '{'{XOC_CTRL_OFS, 32'h0080, 4'h3, XOC_RESP_OKAY, 32'h0080, XOC_RESP_OKAY},
			'{XOC_CTRL_OFS, 32'h0180, 4'h3, XOC_RESP_OKAY, 32'h0180, XOC_RESP_OKAY},
			'{XOC_CTRL_OFS, 32'h0280, 4'h3, XOC_RESP_OKAY, 32'h0280, XOC_RESP_OKAY},
			'{XOC_CTRL_OFS, 32'h0380, 4'h3, XOC_RESP_OKAY, 32'h0380, XOC_RESP_OKAY},
			'{XOC_CTRL_OFS, 32'h0480, 4'h3, XOC_RESP_OKAY, 32'h0480, XOC_RESP_OKAY},
			'{XOC_CTRL_OFS, 32'h0580, 4'h3, XOC_RESP_OKAY, 32'h0480, XOC_RESP_OKAY},
			'{XOC_CTRL_OFS, 32'h0780, 4'h3, XOC_RESP_OKAY, 32'h0480, XOC_RESP_OKAY},
			'{XOC_CTRL_OFS, 32'hff24, 4'h1, XOC_RESP_OKAY, 32'h0404, XOC_RESP_OKAY},
			'{XOC_CTRL_OFS, 32'h0b00, 4'h2, XOC_RESP_OKAY, 32'h0b04, XOC_RESP_OKAY},
			'{XOC_CTRL_OFS, 32'hffff, 4'hc, XOC_RESP_OKAY, 32'h0b04, XOC_RESP_OKAY},
			'{XOC_STATUS_OFS, 32'hffffffff, 4'hf, XOC_RESP_OKAY, 32'h0, XOC_RESP_OKAY},
			'{12'h020, 32'h1234, 4'hf, XOC_RESP_SLVERR, 32'h0, XOC_RESP_SLVERR},
			'{XOC_CTRL_OFS, 32'h0080, 4'h3, XOC_RESP_OKAY, 32'h0080, XOC_RESP_OKAY}};
		pol = '{'{16'h0080, 1'b0, 1'b1, 1'b0}, '{16'h0002, 1'b0, 1'b0, 1'b1}, '{16'h0082, 1'b0, 1'b0, 1'b0},
			'{16'h0082, 1'b0, 1'b1, 1'b1}, '{16'h0002, 1'b1, 1'b0, 1'b0}, '{16'h0002, 1'b1, 1'b1, 1'b1},
			'{16'h0042, 1'b1, 1'b0, 1'b1}, '{16'h00c2, 1'b1, 1'b0, 1'b0}, '{16'h00c2, 1'b1, 1'b1, 1'b1}};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, stall} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{periph_clk_request, standby_sleep, internal_48mhz_ready, pll_lock} = '0;
		{pll_lock_timeout, pll_ratio_update_done, failures, comparisons, cycles} = '0;
		aresetn = 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rchk("ctrl reset", XOC_CTRL_OFS, 32'hffff, 32'h0080);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d, rows[i].s, r);
			chk("bresp", {30'h0, r}, {30'h0, rows[i].b});
			rd(rows[i].a, d, r);
			chk("rdata", d, rows[i].q);
			chk("rresp", {30'h0, r}, {30'h0, rows[i].r});
			if (rows[i].a == XOC_CTRL_OFS) begin
				chk("gain pins", {28'h0, crystal_mode_select, osc_gain}, {28'h0, d[2], d[10:8]});
			end
		end
		internal_48mhz_ready <= 1'b1;
		pll_lock_timeout      <= 1'b1;
		pll_ratio_update_done <= 1'b1;
		pll_lock              <= 1'b1;
		repeat (3) @(posedge aclk);
		rchk("status set", XOC_STATUS_OFS, 32'hffffffff, 32'h0d10);
		pll_lock <= 1'b0;
		repeat (3) @(posedge aclk);
		rchk("status fall", XOC_STATUS_OFS, 32'hffffffff, 32'h0e10);
		{internal_48mhz_ready, pll_lock_timeout, pll_ratio_update_done} <= 3'h0;
		repeat (3) @(posedge aclk);
		rchk("status clear", XOC_STATUS_OFS, 32'hffffffff, 32'h0200);
		foreach (pol[i]) begin
			wr(XOC_CTRL_OFS, {16'h0, pol[i].c}, 4'h3, r);
			standby_sleep      <= pol[i].sb;
			periph_clk_request <= pol[i].rq;
			repeat (3) @(posedge aclk);
			chk("osc_run", {31'h0, osc_run}, {31'h0, pol[i].e});
		end
		wr(XOC_CTRL_OFS, 32'h0080, 4'h3, r);
		{standby_sleep, periph_clk_request} <= 2'h0;
		repeat (3) @(posedge aclk);
		wr(XOC_CTRL_OFS, 32'h2806, 4'h3, r);
		chk("amp early", {31'h0, auto_amplitude_control}, 32'h0);
		for (int k = 0; k < 300 && crystal_ready !== 1'b1; k++) @(posedge aclk);
		chk("ticks", ulpr, 32'h4);
		chk("ready pin", {31'h0, crystal_ready}, 32'h1);
		rchk("ready", XOC_STATUS_OFS, 32'h1, 32'h1);
		chk("amp run", {31'h0, auto_amplitude_control}, 32'h1);
		stall <= 1'b1;
		repeat (150) @(posedge aclk);
		rchk("cfd off", XOC_STATUS_OFS, 32'h6, 32'h0);
		stall <= 1'b0;
		repeat (10) @(posedge aclk);
		wr(XOC_CTRL_OFS, 32'h281e, 4'h3, r);
		chk("xtal mode", {31'h0, crystal_mode_select}, 32'h1);
		stall <= 1'b1;
		repeat (90) @(posedge aclk);
		chk("safe early", {31'h0, safe_clock_select}, 32'h0);
		for (int k = 0; k < 60 && safe_clock_select !== 1'b1; k++) @(posedge aclk);
		rchk("failed", XOC_STATUS_OFS, 32'h6, 32'h6);
		stall <= 1'b0;
		repeat (20) @(posedge aclk);
		rchk("recovered", XOC_STATUS_OFS, 32'h6, 32'h0);
		rchk("swb cleared", XOC_CTRL_OFS, 32'h10, 32'h0);
		chk("safe back", {31'h0, safe_clock_select}, 32'h0);
		wr(XOC_CTRL_OFS, 32'h280e, 4'h3, r);
		stall <= 1'b1;
		for (int k = 0; k < 150 && safe_clock_select !== 1'b1; k++) @(posedge aclk);
		stall <= 1'b0;
		repeat (20) @(posedge aclk);
		rchk("stay switched", XOC_STATUS_OFS, 32'h6, 32'h4);
		chk("safe stays", {31'h0, safe_clock_select}, 32'h1);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rchk("ctrl rereset", XOC_CTRL_OFS, 32'hffff, 32'h0080);
		chk("safe reset", {31'h0, safe_clock_select}, 32'h0);
		chk("run off", {31'h0, osc_run}, 32'h0);
		test_done();
	end
endmodule
`default_nettype wire
